/* logic/startup_switch_config_decoder.sv */
// startup switch bank decoder: protection, boot card transfers,
// port parameter selects, user flag, card push switch operations
// assumes switch and tool inputs synchronous to ref_clk; rst is power-up
// Behaviour
// - position 1 on refuses tool writes
// - position 1 on makes clear spare program
// - position 2 at power-up loads card program
// - position 7 restore outranks automatic load
// - position 4 on selects setup table parameters
// - position 5 on selects tool serial parameters
// - user flag reads inverse of position 6
// - position 7 on, three-second hold backs up
// - position 7 on at power-up restores
// - position 7 off, three-second hold verifies
// - after restore, mode stays program until power-up
`timescale 1ns/1ps
module startup_switch_config_decoder #(
  parameter int HOLD_CYCLES = startup_switch_pkg::HOLD_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // switch bank and card push switch
  input  wire logic [7:0]  switch_bank,
  input  wire logic        card_push,
  // programming tool requests and the gated write, clear and refused outputs
  input  wire logic        tool_wr_req,
  input  wire logic        tool_clr_req,
  output logic             mem_wr_en,
  output logic             mem_clr_en,
  output logic             tool_refused,
  // card operations, one-cycle pulses
  output logic             auto_load_start,
  output logic             restore_start,
  output logic             backup_start,
  output logic             verify_start,
  // port parameter selects, user flag and run mode
  output logic             periph_use_setup,
  output logic             serial_use_setup,
  output logic             user_switch_flag,
  output logic [1:0]       run_mode,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [1:0] {
    BOOT_SAMPLE = 2'b00,
    BOOT_LAUNCH = 2'b01,
    BOOT_DONE   = 2'b10
  } boot_type;

  boot_type    boot_q;
  logic [7:0]  boot_sw_q;
  logic        lock_q;
  logic [31:0] hold_cnt_q;
  logic        hold_fired_q;
  logic        refused_q;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wr_go;
  logic        s_axi_wstrb_any_q;
  logic        mode_ok;
  logic [31:0] status_word;

  // power-up sampling and launch of the boot transfer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_q    <= BOOT_SAMPLE;
      boot_sw_q <= 8'h00;
    end else begin
      case (boot_q)
        BOOT_SAMPLE: begin
          boot_sw_q <= switch_bank;
          boot_q    <= BOOT_LAUNCH;
        end
        BOOT_LAUNCH: boot_q <= BOOT_DONE;
        BOOT_DONE:   boot_q <= BOOT_DONE;
        default:     boot_q <= BOOT_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restore_start   <= 1'b0;
      auto_load_start <= 1'b0;
    end else begin
      restore_start   <= (boot_q == BOOT_LAUNCH) && boot_sw_q[startup_switch_pkg::SW_CARD];
      // restore outranks the automatic load
      auto_load_start <= (boot_q == BOOT_LAUNCH) && boot_sw_q[startup_switch_pkg::SW_AUTOLOAD]
                         && !boot_sw_q[startup_switch_pkg::SW_CARD];
    end
  end

  // only a fresh power-up clears the lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (boot_q == BOOT_LAUNCH && boot_sw_q[startup_switch_pkg::SW_CARD]) begin
      // locks with the restore pulse, before any mode write can complete
      lock_q <= 1'b1;
    end
  end

  // card push switch hold timer; one operation per press
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_q   <= 32'h0000_0000;
      hold_fired_q <= 1'b0;
      backup_start <= 1'b0;
      verify_start <= 1'b0;
    end else begin
      backup_start <= 1'b0;
      verify_start <= 1'b0;
      if (!card_push) begin
        hold_cnt_q   <= 32'h0000_0000;
        hold_fired_q <= 1'b0;
      end else if (!hold_fired_q) begin
        if (hold_cnt_q == 32'(HOLD_CYCLES - 1)) begin
          hold_fired_q <= 1'b1;
          backup_start <= switch_bank[startup_switch_pkg::SW_CARD];
          verify_start <= !switch_bank[startup_switch_pkg::SW_CARD];
        end else begin
          hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // tool access gate follows the live protect switch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_wr_en    <= 1'b0;
      mem_clr_en   <= 1'b0;
      tool_refused <= 1'b0;
    end else begin
      mem_wr_en    <= tool_wr_req && !switch_bank[startup_switch_pkg::SW_PROTECT];
      mem_clr_en   <= tool_clr_req && !switch_bank[startup_switch_pkg::SW_PROTECT];
      tool_refused <= (tool_wr_req || tool_clr_req)
                      && switch_bank[startup_switch_pkg::SW_PROTECT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periph_use_setup <= 1'b0;
      serial_use_setup <= 1'b1;
      user_switch_flag <= 1'b1;
    end else begin
      periph_use_setup <= switch_bank[startup_switch_pkg::SW_PERIPH];
      serial_use_setup <= !switch_bank[startup_switch_pkg::SW_SERIAL];
      user_switch_flag <= !switch_bank[startup_switch_pkg::SW_USER];
    end
  end

  // axi write: address and data taken in either order
  assign wr_go   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign mode_ok = (wdata_q[1:0] == startup_switch_pkg::MODE_PROGRAM)
                   || (!lock_q && (wdata_q[1:0] != 2'b11));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= startup_switch_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_hold_q && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_hold_q && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == startup_switch_pkg::ADDR_CTRL && mode_ok) begin
          s_axi_bresp <= startup_switch_pkg::RESP_OKAY;
        end else if (awaddr_q == startup_switch_pkg::ADDR_STATUS
                     || awaddr_q == startup_switch_pkg::ADDR_SWITCH) begin
          s_axi_bresp <= startup_switch_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= startup_switch_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // mode register; a locked device refuses anything but program
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_mode  <= startup_switch_pkg::MODE_RESET;
      refused_q <= 1'b0;
    end else if (wr_go && awaddr_q == startup_switch_pkg::ADDR_CTRL
                 && s_axi_wstrb_any_q) begin
      if (mode_ok) begin
        run_mode  <= wdata_q[1:0];
        refused_q <= 1'b0;
      end else begin
        refused_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_wstrb_any_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wstrb_any_q <= s_axi_wstrb[0];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[startup_switch_pkg::ST_BOOT_SW +: 8] = boot_sw_q;
    status_word[startup_switch_pkg::ST_MODE +: 2]    = run_mode;
    status_word[startup_switch_pkg::ST_LOCK]         = lock_q;
    status_word[startup_switch_pkg::ST_FLAG]         = user_switch_flag;
    status_word[startup_switch_pkg::ST_REFUSED]      = refused_q;
  end

  // axi read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= startup_switch_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= startup_switch_pkg::RESP_OKAY;
        case (s_axi_araddr)
          startup_switch_pkg::ADDR_CTRL:   s_axi_rdata <= {30'h0, run_mode};
          startup_switch_pkg::ADDR_STATUS: s_axi_rdata <= status_word;
          startup_switch_pkg::ADDR_SWITCH: s_axi_rdata <= {24'h0, switch_bank};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= startup_switch_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence s_launch;
    boot_q == BOOT_LAUNCH;
  endsequence

  property p_protect_wr;
    @(posedge ref_clk) disable iff (rst)
      tool_wr_req && switch_bank[0] |=> !mem_wr_en && tool_refused;
  endproperty
  a_protect_wr: assert property (p_protect_wr) else $error("protected write passed");

  property p_protect_clr;
    @(posedge ref_clk) disable iff (rst)
      tool_clr_req |=> mem_clr_en == !$past(switch_bank[0]);
  endproperty
  a_protect_clr: assert property (p_protect_clr) else $error("clear gate wrong");

  property p_autoload;
    @(posedge ref_clk) disable iff (rst)
      s_launch |=> auto_load_start == (boot_sw_q[1] && !boot_sw_q[6]);
  endproperty
  a_autoload: assert property (p_autoload) else $error("auto load decision wrong");

  property p_priority;
    @(posedge ref_clk) disable iff (rst)
      boot_q == BOOT_LAUNCH && boot_sw_q[6] |=> restore_start && !auto_load_start;
  endproperty
  a_priority: assert property (p_priority) else $error("load and restore together");

  property p_selects;
    @(posedge ref_clk) disable iff (rst)
      1'b1 |=> periph_use_setup == $past(switch_bank[3])
               && serial_use_setup == !$past(switch_bank[4]);
  endproperty
  a_selects: assert property (p_selects) else $error("port select wrong");

  property p_flag;
    @(posedge ref_clk) disable iff (rst)
      $changed(switch_bank[5]) |=> user_switch_flag == !$past(switch_bank[5]);
  endproperty
  a_flag: assert property (p_flag) else $error("user flag sense wrong");

  property p_hold_op;
    @(posedge ref_clk) disable iff (rst)
      (backup_start || verify_start) |->
        $past(card_push) && backup_start != verify_start
        && backup_start == $past(switch_bank[6])
        && $past(hold_cnt_q) == 32'(HOLD_CYCLES - 1);
  endproperty
  a_hold_op: assert property (p_hold_op) else $error("card operation without hold");

  property p_restore;
    @(posedge ref_clk) disable iff (rst)
      s_launch ##1 restore_start |=> lock_q [*2];
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not lock");

  property p_lock;
    @(posedge ref_clk) disable iff (rst)
      lock_q |-> run_mode == startup_switch_pkg::MODE_PROGRAM;
  endproperty
  a_lock: assert property (p_lock) else $error("locked mode left program");

  property p_sample_once;
    @(posedge ref_clk) disable iff (rst)
      boot_q == BOOT_DONE |=> $stable(boot_sw_q);
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("boot sample changed");
endmodule : startup_switch_config_decoder

/* logic/startup_switch_pkg.sv */
// constants for the startup switch bank decoder
// assumes a 25 MHz ref_clk and an AXI4-Lite register slave
package startup_switch_pkg;
  // switch positions, bit index = position - 1
  localparam int SW_PROTECT  = 0;
  localparam int SW_AUTOLOAD = 1;
  localparam int SW_PERIPH   = 3;
  localparam int SW_SERIAL   = 4;
  localparam int SW_USER     = 5;
  localparam int SW_CARD     = 6;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SWITCH = 8'h08;

  // status field positions
  localparam int ST_BOOT_SW  = 0;
  localparam int ST_MODE     = 8;
  localparam int ST_LOCK     = 10;
  localparam int ST_FLAG     = 11;
  localparam int ST_REFUSED  = 12;

  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_RUN     = 2'b10
  } mode_type;

  localparam mode_type MODE_RESET = MODE_PROGRAM;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // card push switch hold time
  localparam int CLK_HZ      = 25000000;
  localparam int HOLD_TIME_S = 3;
  localparam int HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;
endpackage : startup_switch_pkg

/* verification/testbench.sv */
// self-checking bench for the startup switch decoder
// assumes the package, the decoder and tool_card_model are compiled before it
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 34'(e), 34'(g))
module testbench;
  localparam int HOLD = 8;
  logic        ref_clk, rst, card_push, tool_wr_req, tool_clr_req;
  logic [7:0]  switch_bank, s_axi_awaddr, s_axi_araddr, sw;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, run_mode;
  logic        mem_wr_en, mem_clr_en, tool_refused, auto_load_start, restore_start;
  logic        backup_start, verify_start, periph_use_setup, serial_use_setup;
  logic        user_switch_flag, strb_lo;
  logic [6:0]  pulses;
  logic [33:0] exp_q[$];
  int          bad_count = 0;
  int          comparisons = 0;

  assign pulses = {auto_load_start, restore_start, backup_start, verify_start,
                   mem_wr_en, mem_clr_en, tool_refused};

  startup_switch_config_decoder #(.HOLD_CYCLES(HOLD)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .switch_bank(switch_bank), .card_push(card_push),
    .tool_wr_req(tool_wr_req), .tool_clr_req(tool_clr_req), .mem_wr_en(mem_wr_en),
    .mem_clr_en(mem_clr_en), .tool_refused(tool_refused), .auto_load_start(auto_load_start),
    .restore_start(restore_start), .backup_start(backup_start), .verify_start(verify_start),
    .periph_use_setup(periph_use_setup), .serial_use_setup(serial_use_setup),
    .user_switch_flag(user_switch_flag), .run_mode(run_mode),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  tool_card_model model_u (
    .ref_clk(ref_clk), .tool_wr_req(tool_wr_req), .tool_clr_req(tool_clr_req),
    .card_push(card_push)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic limit(input int n);
    if (n >= 40) begin
      bad_count++;
      $display("CHECK FAILED handshake expected answer seen none");
      stop_test();
    end
  endtask : limit

  // results are judged in order of appearance; a surprise result meets an x
  task automatic pop_cmp(input string n, input logic [33:0] g);
    logic [33:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
    `CHK(n, e, g);
  endtask : pop_cmp

  always @(posedge ref_clk) begin
    if (!rst) begin
      if (s_axi_bvalid && s_axi_bready) pop_cmp("write response", {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready) pop_cmp("read response", {s_axi_rresp, s_axi_rdata});
      if (|pulses) pop_cmp("start pulses", {27'h0, pulses});
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({r, 32'h0});
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= {3'($urandom), strb_lo};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    limit(n);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({r, d});
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    limit(n);
  endtask : axi_rd

  task automatic boot(input logic [7:0] bsw, input logic [6:0] p);
    @(posedge ref_clk);
    switch_bank <= bsw;
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    `CHK("reset levels", 5'b01100,
         {periph_use_setup, serial_use_setup, user_switch_flag, run_mode});
    if (p != 7'h00) exp_q.push_back({27'h0, p});
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : boot

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("CHECK FAILED run length expected end seen hang");
    stop_test();
  end

  initial begin
    rst = 1'b1;
    switch_bank = 8'h00;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    strb_lo = 1'b1;
    void'($urandom(32'h34cf));
    boot(8'h42, 7'h20);
    axi_wr(startup_switch_pkg::ADDR_CTRL, 32'h1, startup_switch_pkg::RESP_SLVERR);
    axi_wr(startup_switch_pkg::ADDR_CTRL, 32'h2, startup_switch_pkg::RESP_SLVERR);
    `CHK("locked mode", 2'b00, run_mode);
    sw = 8'($urandom);
    switch_bank <= sw;
    repeat (3) @(posedge ref_clk);
    axi_rd(startup_switch_pkg::ADDR_STATUS, {19'h0, 1'b1, !sw[5], 1'b1, 2'b00, 8'h42},
           startup_switch_pkg::RESP_OKAY);
    axi_rd({1'b1, 7'($urandom)}, 32'h0, startup_switch_pkg::RESP_SLVERR);
    axi_wr({1'b1, 7'($urandom)}, $urandom, startup_switch_pkg::RESP_SLVERR);
    axi_wr(startup_switch_pkg::ADDR_STATUS, $urandom, startup_switch_pkg::RESP_OKAY);
    boot(8'h02, 7'h40);
    axi_wr(startup_switch_pkg::ADDR_CTRL, ($urandom & 32'hfffffffc) | 32'h1,
           startup_switch_pkg::RESP_OKAY);
    `CHK("monitor mode", 2'b01, run_mode);
    axi_wr(startup_switch_pkg::ADDR_CTRL, 32'h2, startup_switch_pkg::RESP_OKAY);
    axi_wr(startup_switch_pkg::ADDR_CTRL, 32'h3, startup_switch_pkg::RESP_SLVERR);
    `CHK("run mode kept", 2'b10, run_mode);
    // a mode write without its low byte strobe is answered but not applied
    strb_lo = 1'b0;
    axi_wr(startup_switch_pkg::ADDR_CTRL, 32'h1, startup_switch_pkg::RESP_OKAY);
    strb_lo = 1'b1;
    `CHK("strobe ignored", 2'b10, run_mode);
    axi_rd(startup_switch_pkg::ADDR_STATUS, {19'h0, 5'b11010, 8'h02},
           startup_switch_pkg::RESP_OKAY);
    boot(8'h00, 7'h00);
    for (int i = 0; i < 6; i++) begin
      sw = 8'($urandom);
      switch_bank <= sw;
      repeat (3) @(posedge ref_clk);
      `CHK("peripheral select", sw[3], periph_use_setup);
      `CHK("serial select", !sw[4], serial_use_setup);
      `CHK("user flag", !sw[5], user_switch_flag);
      axi_rd(startup_switch_pkg::ADDR_SWITCH, {24'h0, sw}, startup_switch_pkg::RESP_OKAY);
    end
    switch_bank <= 8'h01;
    repeat (2) @(posedge ref_clk);
    exp_q.push_back(34'h01);
    model_u.send(1'b1);
    exp_q.push_back(34'h01);
    model_u.send(1'b0);
    switch_bank <= 8'h40;
    repeat (2) @(posedge ref_clk);
    exp_q.push_back(34'h04);
    model_u.send(1'b1);
    exp_q.push_back(34'h02);
    model_u.send(1'b0);
    exp_q.push_back(34'h10);
    model_u.press(HOLD + 4);
    switch_bank <= 8'h00;
    exp_q.push_back(34'h08);
    model_u.press(HOLD + 4);
    model_u.press(HOLD - 2);
    repeat (4) @(posedge ref_clk);
    `CHK("results outstanding", 0, exp_q.size());
    stop_test();
  end
endmodule : testbench

/* verification/tool_card_model.sv */
// far side of the decoder: programming tool requests and the card push switch
// assumes the bench calls its tasks from a process clocked by ref_clk
`timescale 1ns/1ps
module tool_card_model (
  // clock
  input  wire logic ref_clk,
  // requests towards the decoder
  output logic      tool_wr_req,
  output logic      tool_clr_req,
  output logic      card_push
);
  initial begin
    tool_wr_req = 1'b0;
    tool_clr_req = 1'b0;
    card_push = 1'b0;
  end
  // one request cycle, dropped at the next edge
  task automatic send(input logic wr);
    @(posedge ref_clk);
    tool_wr_req  <= wr;
    tool_clr_req <= !wr;
    @(posedge ref_clk);
    tool_wr_req  <= 1'b0;
    tool_clr_req <= 1'b0;
  endtask : send
  // a hold shorter than the timer shows that an early release starts no operation
  task automatic press(input int cycles);
    @(posedge ref_clk);
    card_push <= 1'b1;
    repeat (cycles) @(posedge ref_clk);
    card_push <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : press
endmodule : tool_card_model
